// ===== logic/lzp_pkg.sv
/*
 * shared constants for the calibration / power-down command block.
 * assumes a 200 MHz core clock standing in for the memory clock.
 */
package lzp_pkg;
    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    localparam logic [7:0] CAL_MR_ADDR = 8'h0A;
    localparam logic [7:0] CAL_CODE_INIT = 8'hFF;
    localparam logic [7:0] CAL_CODE_LONG = 8'hAB;
    localparam logic [7:0] CAL_CODE_SHORT = 8'h56;
    localparam logic [7:0] CAL_CODE_RESET = 8'hC3;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int T_ZQINIT_NS = 1000;
    localparam int T_ZQCL_NS = 360;
    localparam int T_ZQCS_NS = 90;
    localparam int T_ZQRESET_NS = 50;
    localparam int ZQINIT_CYC = (T_ZQINIT_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int ZQCL_CYC = (T_ZQCL_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int ZQCS_CYC = (T_ZQCS_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int ZQRESET_CYC = (T_ZQRESET_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int CNT_W = 12;
    // ------------------------------------------------------------
    // impedance codes
    // ------------------------------------------------------------
    localparam int IMP_W = 6;
    localparam logic [5:0] IMP_DEFAULT = 6'h20;
    localparam logic [5:0] IMP_TRIMMED = 6'h28;

    typedef enum logic [1:0] {
        LZP_CAL_INIT,
        LZP_CAL_LONG,
        LZP_CAL_SHORT,
        LZP_CAL_RESET
    } lzp_cal_t;
endpackage

// ===== logic/lzp_cal_timer.sv
/*
 * calibration window timer: loads a cycle count, counts down, pulses done.
 * assumes the caller loads only while idle.
 */
`timescale 1ns/1ps
module lzp_cal_timer #(
    parameter int W = lzp_pkg::CNT_W
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic next_busy;
    logic next_done;

    always_comb begin
        next_cnt = cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (load) begin
            next_cnt = count;
            next_busy = 1'b1;
        end else if (busy) begin
            if (cnt <= W'(1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
                next_cnt = '0;
            end else begin
                next_cnt = cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule

// ===== logic/lzp_ctrl.sv
/*
 * command-side state of the memory die for impedance calibration,
 * power-down and deep power-down.
 * assumes command pins already sampled at the rising clock, the
 * two-edge mode register write assembled into one pulse upstream.
 */
`timescale 1ns/1ps
module lzp_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cke,
    input wire logic cs_b,
    input wire logic [2:0] ca,
    input wire logic mrw_valid,
    input wire logic [7:0] mrw_addr,
    input wire logic [7:0] mrw_data,
    input wire logic zq_tied_supply,
    input wire logic init_done,
    output logic in_power_down,
    output logic in_deep_power_down,
    output logic buffers_enable,
    output logic refresh_enable,
    output logic array_valid,
    output logic need_init,
    output logic cal_busy,
    output logic zq_enable,
    output logic [lzp_pkg::IMP_W-1:0] imp_code
);
    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    typedef enum {
        LZP_ACTIVE,
        LZP_PD,
        LZP_DPD,
        LZP_REINIT
    } lzp_pwr_t;

    lzp_pwr_t pwr;
    lzp_pwr_t next_pwr;
    logic cke_q;
    logic next_cke_q;
    logic dpd_code;

    assign dpd_code = !cs_b && ca[0] && ca[1] && !ca[2];

    always_comb begin
        next_pwr = pwr;
        next_cke_q = cke;
        unique case (pwr)
            LZP_ACTIVE: begin
                // timer busy means controller broke the cke-high window
                if (cke_q && !cke && !cal_busy) begin
                    if (cs_b) begin
                        next_pwr = LZP_PD;
                    end else if (dpd_code) begin
                        next_pwr = LZP_DPD;
                    end
                end
            end
            LZP_PD: begin
                // other inputs are don't care here
                if (cke) begin
                    next_pwr = LZP_ACTIVE;
                end
            end
            LZP_DPD: begin
                if (cke) begin
                    next_pwr = LZP_REINIT;
                end
            end
            LZP_REINIT: begin
                if (init_done) begin
                    next_pwr = LZP_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pwr <= LZP_ACTIVE;
            cke_q <= 1'b1;
        end else begin
            pwr <= next_pwr;
            cke_q <= next_cke_q;
        end
    end

    // ------------------------------------------------------------
    // power state outputs
    // ------------------------------------------------------------
    logic next_in_power_down;
    logic next_in_deep_power_down;
    logic next_buffers_enable;
    logic next_refresh_enable;
    logic next_array_valid;
    logic next_need_init;

    always_comb begin
        next_in_power_down = next_pwr == LZP_PD;
        next_in_deep_power_down = next_pwr == LZP_DPD;
        // only clock and cke stay live while asleep
        next_buffers_enable = next_pwr != LZP_PD && next_pwr != LZP_DPD;
        // no refresh in either sleep state
        next_refresh_enable = next_pwr == LZP_ACTIVE;
        next_need_init = next_pwr == LZP_REINIT;
        next_array_valid = array_valid;
        if (next_pwr == LZP_DPD) begin
            next_array_valid = 1'b0;
        end else if (pwr == LZP_REINIT && next_pwr == LZP_ACTIVE) begin
            next_array_valid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_power_down <= 1'b0;
            in_deep_power_down <= 1'b0;
            buffers_enable <= 1'b1;
            refresh_enable <= 1'b1;
            array_valid <= 1'b1;
            need_init <= 1'b0;
        end else begin
            in_power_down <= next_in_power_down;
            in_deep_power_down <= next_in_deep_power_down;
            buffers_enable <= next_buffers_enable;
            refresh_enable <= next_refresh_enable;
            array_valid <= next_array_valid;
            need_init <= next_need_init;
        end
    end

    // ------------------------------------------------------------
    // calibration
    // ------------------------------------------------------------
    // unknown codes are plain mode writes, not calibrations
    function automatic logic code_known(input logic [7:0] code);
        return code == lzp_pkg::CAL_CODE_INIT
            || code == lzp_pkg::CAL_CODE_LONG
            || code == lzp_pkg::CAL_CODE_SHORT
            || code == lzp_pkg::CAL_CODE_RESET;
    endfunction

    function automatic lzp_pkg::lzp_cal_t code_kind(
        input logic [7:0] code
    );
        lzp_pkg::lzp_cal_t k;
        k = lzp_pkg::LZP_CAL_RESET;
        if (code == lzp_pkg::CAL_CODE_INIT) begin
            k = lzp_pkg::LZP_CAL_INIT;
        end else if (code == lzp_pkg::CAL_CODE_LONG) begin
            k = lzp_pkg::LZP_CAL_LONG;
        end else if (code == lzp_pkg::CAL_CODE_SHORT) begin
            k = lzp_pkg::LZP_CAL_SHORT;
        end
        return k;
    endfunction

    // window length per kind, rounded up to whole clocks
    function automatic logic [lzp_pkg::CNT_W-1:0] cal_cycles(
        input lzp_pkg::lzp_cal_t kind
    );
        logic [lzp_pkg::CNT_W-1:0] n;
        n = lzp_pkg::ZQRESET_CYC[lzp_pkg::CNT_W-1:0];
        unique case (kind)
            lzp_pkg::LZP_CAL_INIT: begin
                n = lzp_pkg::ZQINIT_CYC[lzp_pkg::CNT_W-1:0];
            end
            lzp_pkg::LZP_CAL_LONG: begin
                n = lzp_pkg::ZQCL_CYC[lzp_pkg::CNT_W-1:0];
            end
            lzp_pkg::LZP_CAL_SHORT: begin
                n = lzp_pkg::ZQCS_CYC[lzp_pkg::CNT_W-1:0];
            end
            lzp_pkg::LZP_CAL_RESET: begin
                n = lzp_pkg::ZQRESET_CYC[lzp_pkg::CNT_W-1:0];
            end
        endcase
        return n;
    endfunction

    logic cal_cmd;
    logic cal_load;
    logic cal_done;
    logic [lzp_pkg::CNT_W-1:0] cal_count;
    lzp_pkg::lzp_cal_t kind;
    lzp_pkg::lzp_cal_t next_kind;
    logic next_zq_enable;
    logic [lzp_pkg::IMP_W-1:0] next_imp_code;

    // awake, cke high and no window open; a second request while
    // busy is dropped rather than queued
    assign cal_cmd = mrw_valid && mrw_addr == lzp_pkg::CAL_MR_ADDR
        && code_known(mrw_data) && !cal_busy && cke
        && (pwr == LZP_ACTIVE || pwr == LZP_REINIT);
    // no resistor fitted: keep the current setting
    assign cal_load = cal_cmd && !zq_tied_supply;
    assign cal_count = cal_cycles(code_kind(mrw_data));

    lzp_cal_timer #(
        .W(lzp_pkg::CNT_W)
    ) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .load(cal_load),
        .count(cal_count),
        .busy(cal_busy),
        .done(cal_done)
    );

    always_comb begin
        next_kind = kind;
        next_zq_enable = zq_enable;
        next_imp_code = imp_code;
        if (cal_done) begin
            // pin circuitry off again to save power
            next_zq_enable = 1'b0;
            if (kind == lzp_pkg::LZP_CAL_RESET) begin
                next_imp_code = lzp_pkg::IMP_DEFAULT;
            end else begin
                next_imp_code = lzp_pkg::IMP_TRIMMED;
            end
        end
        if (cal_load) begin
            next_kind = code_kind(mrw_data);
            // reset needs no resistor, so the pin stays off
            next_zq_enable = code_kind(mrw_data) != lzp_pkg::LZP_CAL_RESET;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            kind <= lzp_pkg::LZP_CAL_RESET;
            zq_enable <= 1'b0;
            imp_code <= lzp_pkg::IMP_DEFAULT;
        end else begin
            kind <= next_kind;
            zq_enable <= next_zq_enable;
            imp_code <= next_imp_code;
        end
    end
endmodule

// ===== bench/lzp_ctrl_props.sv
/* port checker for lzp_ctrl.
   assumes one clock and the asynchronous low reset. */
`timescale 1ns/1ps
module lzp_ctrl_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cke,
    input wire logic cs_b,
    input wire logic mrw_valid,
    input wire logic zq_tied_supply,
    input wire logic [2:0] ca,
    input wire logic [7:0] mrw_addr,
    input wire logic [7:0] mrw_data,
    input wire logic in_power_down,
    input wire logic in_deep_power_down,
    input wire logic buffers_enable,
    input wire logic refresh_enable,
    input wire logic array_valid,
    input wire logic need_init,
    input wire logic cal_busy,
    input wire logic [lzp_pkg::IMP_W-1:0] imp_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic zq;
    logic idle;
    assign idle = !in_power_down && !in_deep_power_down && !cal_busy;
    assign zq = mrw_valid && mrw_addr == lzp_pkg::CAL_MR_ADDR && idle && cke;
    a_pd_entry: assert property (idle && !cke && cs_b
        |-> ##[1:2] in_power_down) else $error("no power-down entry");
    a_pd_exit: assert property (in_power_down && cke
        |-> ##[1:2] !in_power_down) else $error("no power-down exit");
    a_pd_buffers: assert property (in_power_down
        |-> !buffers_enable) else $error("buffers on in power-down");
    a_pd_refresh: assert property (in_power_down
        |-> !refresh_enable) else $error("refresh in power-down");
    a_dpd_entry: assert property (idle && !cke && !cs_b
        && ca == 3'h3 |-> ##[1:2] in_deep_power_down) else $error("no dpd");
    a_dpd_array: assert property (in_deep_power_down
        |-> !array_valid) else $error("array valid in dpd");
    a_dpd_init: assert property ($fell(in_deep_power_down)
        |-> need_init) else $error("dpd exit without init need");
    a_zq_tied: assert property (zq && zq_tied_supply
        |=> !cal_busy) else $error("tied pin still calibrates");
    a_zq_start: assert property (zq && !zq_tied_supply
        && mrw_data == lzp_pkg::CAL_CODE_LONG |-> ##[1:2] cal_busy)
        else $error("calibration not started");
    a_zq_reset: assert property (zq && !zq_tied_supply
        && mrw_data == lzp_pkg::CAL_CODE_RESET
        |-> ##[1:20] imp_code == lzp_pkg::IMP_DEFAULT)
        else $error("impedance not back to default");
    cover property (in_power_down);
    cover property (in_deep_power_down);
    cover property ($fell(cal_busy));
endmodule
bind lzp_ctrl lzp_ctrl_props u_props (.*);

// ===== bench/lzp_host_model.sv
/* controller model on the command pins of lzp_ctrl.
   assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module lzp_host_model (
    input wire logic clk,
    output logic cke,
    output logic cs_b,
    output logic mrw_valid,
    output logic [2:0] ca,
    output logic [7:0] mrw_addr,
    output logic [7:0] mrw_data
);
    initial begin
        cke = 1'b1;
        cs_b = 1'b1;
        ca = 3'h7;
        mrw_valid = 1'b0;
        mrw_addr = 8'h00;
        mrw_data = 8'h00;
    end
    // sleep entry only from idle, no burst or mode access in flight
    task automatic cmd(input logic k, input logic s, input logic [2:0] c);
        @(posedge clk);
        cke <= k; // cke held low until exit
        cs_b <= s;
        ca <= c;
        @(posedge clk);
        cs_b <= 1'b1; // nop after entry
        ca <= ~c;
    endtask
    // issued only from idle, cke high, nop-only after
    task automatic mrw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        mrw_valid <= 1'b1;
        mrw_addr <= a;
        mrw_data <= d;
        @(posedge clk);
        mrw_valid <= 1'b0;
        mrw_addr <= ~a;
        mrw_data <= ~d;
    endtask
endmodule

// ===== bench/tb_lzp_ctrl.sv
/* bench for lzp_ctrl with the host model on its command side.
   assumes the package timing at a 5 ns clock. */
`timescale 1ns/1ps
module tb_lzp_ctrl;
    logic clk, rst_b, tied, idn, cke, cs_b, mv, pd, dpd, be, re, av, ni, bsy;
    logic zen;
    logic [2:0] ca;
    logic [7:0] ma, md;
    logic [lzp_pkg::IMP_W-1:0] imp;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    // long enough for a wrongly started long window to show
    localparam int ZQ_SETTLE = lzp_pkg::ZQCL_CYC + 4;
    lzp_host_model host (.clk(clk), .cke(cke), .cs_b(cs_b), .mrw_valid(mv),
        .ca(ca), .mrw_addr(ma), .mrw_data(md));
    lzp_ctrl dut (.clk(clk), .rst_b(rst_b), .cke(cke), .cs_b(cs_b), .ca(ca),
        .mrw_valid(mv), .mrw_addr(ma), .mrw_data(md), .zq_tied_supply(tied),
        .init_done(idn), .in_power_down(pd), .in_deep_power_down(dpd),
        .buffers_enable(be), .refresh_enable(re), .array_valid(av),
        .need_init(ni), .cal_busy(bsy), .zq_enable(zen), .imp_code(imp));
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic t_cal(input logic [7:0] code, input int n);
        host.mrw(lzp_pkg::CAL_MR_ADDR, code);
        w(2);
        chk(bsy, 1'b1);
        chk(zen, code != lzp_pkg::CAL_CODE_RESET);
        w(n - 3);
        chk(bsy, 1'b1);
        w(1);
        chk(bsy, 1'b0);
        w(1);
        chk(zen, 1'b0);
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        rst_b = 1'b0;
        tied = 1'b0;
        idn = 1'b0;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        idn <= 1'b1;
        t_cal(lzp_pkg::CAL_CODE_INIT, lzp_pkg::ZQINIT_CYC);
        chk(imp, lzp_pkg::IMP_TRIMMED);
        t_cal(lzp_pkg::CAL_CODE_LONG, lzp_pkg::ZQCL_CYC);
        t_cal(lzp_pkg::CAL_CODE_SHORT, lzp_pkg::ZQCS_CYC);
        t_cal(lzp_pkg::CAL_CODE_RESET, lzp_pkg::ZQRESET_CYC);
        chk(imp, lzp_pkg::IMP_DEFAULT);
        @(posedge clk);
        tied <= 1'b1;
        host.mrw(lzp_pkg::CAL_MR_ADDR, lzp_pkg::CAL_CODE_LONG);
        w(2);
        chk(bsy, 1'b0);
        chk(zen, 1'b0);
        w(ZQ_SETTLE);
        chk(imp, lzp_pkg::IMP_DEFAULT);
        @(posedge clk);
        tied <= 1'b0;
        host.cmd(1'b0, 1'b1, 3'h7);
        w(2);
        chk(pd, 1'b1);
        chk(be, 1'b0);
        chk(re, 1'b0);
        host.cmd(1'b1, 1'b1, 3'h7);
        w(3);
        chk(pd, 1'b0);
        host.cmd(1'b0, 1'b0, 3'h3);
        w(2);
        chk(dpd, 1'b1);
        chk(av, 1'b0);
        @(posedge clk);
        idn <= 1'b0;
        host.cmd(1'b1, 1'b1, 3'h7);
        w(3);
        chk(dpd, 1'b0);
        chk(ni, 1'b1);
        chk(av, 1'b0);
        @(posedge clk);
        idn <= 1'b1;
        w(2);
        chk(ni, 1'b0);
        chk(av, 1'b1);
        tally_and_finish();
    end
endmodule
